// ===== standby_pkg.sv
`default_nettype none
package standby_pkg;

   // ****************************************************************
   // register map and layout
   // ****************************************************************
   localparam logic [15:0] ADDR_PROGRESS  = 16'hffa3;
   localparam logic [15:0] ADDR_SELECT    = 16'hffa4;
   localparam int          SEL_W          = 3;
   localparam int          FLAG_NUM       = 5;
   localparam int          DATA_W         = 8;
   localparam logic [2:0]  SELECT_RESET   = 3'h5;
   localparam logic [4:0]  PROGRESS_RESET = 5'h00;
   localparam logic [7:0]  READ_ZERO      = 8'h00;

   // select codes
   localparam logic [2:0] SEL_2E11 = 3'h1;
   localparam logic [2:0] SEL_2E13 = 3'h2;
   localparam logic [2:0] SEL_2E14 = 3'h3;
   localparam logic [2:0] SEL_2E15 = 3'h4;
   localparam logic [2:0] SEL_2E16 = 3'h5;

   // ****************************************************************
   // settling counter, counted in crystal periods
   // ****************************************************************
   localparam int          CNT_W     = 17;
   localparam logic [16:0] CNT_ZERO  = 17'h0_0000;
   localparam logic [16:0] CNT_ONE   = 17'h0_0001;
   localparam logic [16:0] THR_2E11  = 17'h0_0800;
   localparam logic [16:0] THR_2E13  = 17'h0_2000;
   localparam logic [16:0] THR_2E14  = 17'h0_4000;
   localparam logic [16:0] THR_2E15  = 17'h0_8000;
   localparam logic [16:0] THR_2E16  = 17'h1_0000;

   // status bit i: bit 4 is the 2^11 flag, bit 0 the 2^16 flag
   localparam logic [4:0][16:0] FLAG_THR = {THR_2E11, THR_2E13, THR_2E14,
                                            THR_2E15, THR_2E16};

   // limit per select code; prohibited codes fall back to the longest
   localparam logic [7:0][16:0] LIMIT_BY_CODE = {
      THR_2E16, THR_2E16, THR_2E16, THR_2E15,
      THR_2E14, THR_2E13, THR_2E11, THR_2E16};

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_RUN,
      ST_HALT,
      ST_STOP,
      ST_SETTLE
   } standby_state_t;

   typedef struct packed {
      logic cpu_clk_run;
      logic crystal_osc_run;
      logic int_hs_osc_run;
      logic state_hold;
   } clk_ctl_t;

   localparam clk_ctl_t CTL_RESET = '{cpu_clk_run: 1'b1, crystal_osc_run: 1'b1,
                                      int_hs_osc_run: 1'b1, state_hold: 1'b0};

endpackage
`default_nettype wire

// ===== standby_osc_settle_control.sv
// Summary of operation
// R1: halt instruction gates cpu clock; running oscillators keep running.
// R2: interrupt request ends halt at once, without any settling wait.
// R3: stop instruction halts crystal and internal high-speed oscillators.
// R4: interrupt request ends stop mode.
// R5: stop release on crystal clock waits for oscillation settling first.
// R6: registers, flags and memory are held unchanged during standby.
// R7: port latches and output buffers are held during standby.
// R8: stop only on main clock; halt on any clock; subclock never stops.
// R9: software stops main-clock peripherals before the stop instruction.
// R10: software should clear adc run and enable bits before stop.
// R11: progress register shows how far crystal settling has counted.
// R12: progress clears on reset, stop instruction, and main osc halt bit.
// R13: five flags set in thermometer order at 2^11..2^16 periods, sticky.
// R14: counter stops at selected limit; software picks a long enough limit.
// R15: counting starts only once the crystal actually oscillates.
// R16: select codes 1..5 mean 2^11..2^16; others prohibited; resets to 5.
// R17: with crystal as cpu clock, resume after stop once limit elapsed.
// R18: reset during standby ends it and runs normal reset.
`timescale 1ns/1ns
`default_nettype none
module standby_osc_settle_control
   import standby_pkg::*;
#(
   parameter int unsigned SETTLE_SHIFT = 0
) (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              halt_instr,
   input  wire logic              stop_instr,
   input  wire logic              irq_pending,
   input  wire logic              cpu_on_main_clk,
   input  wire logic              cpu_on_crystal,
   input  wire logic              main_osc_halt_bit,
   input  wire logic              main_crystal_osc_tick,
   input  wire logic              main_crystal_osc_alive,
   input  wire logic [15:0]       reg_addr,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0]      reg_rdata,
   output clk_ctl_t               clk_ctl
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   standby_state_t        state_ff;
   standby_state_t        nxt_state;
   clk_ctl_t              ctl_ff;
   clk_ctl_t              nxt_ctl;
   logic [SEL_W-1:0]      sel_ff;
   logic [CNT_W-1:0]      count_ff;
   logic [CNT_W-1:0]      nxt_count;
   logic [FLAG_NUM-1:0]   flags_ff;
   logic [FLAG_NUM-1:0]   nxt_flags;
   logic [DATA_W-1:0]     rdata_ff;
   logic [DATA_W-1:0]     nxt_rdata;
   logic [2:0]            tick_sync_ff;
   logic [1:0]            alive_sync_ff;
   logic                  tick_rise;
   logic                  osc_ok;
   logic                  stop_accept;
   logic                  clear_progress;
   logic                  at_limit;
   logic                  sel_wr;
   logic [CNT_W-1:0]      limit;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   // crystal pins are asynchronous to clk; the first stage feeds only
   // the second, the edge detector looks at later stages
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_sync_ff  <= 3'h0;
         alive_sync_ff <= 2'h0;
      end else begin
         tick_sync_ff  <= {tick_sync_ff[1:0], main_crystal_osc_tick};
         alive_sync_ff <= {alive_sync_ff[0], main_crystal_osc_alive};
      end
   end

   // one crystal period seen; crystal must run at clk/4 or slower
   assign tick_rise = tick_sync_ff[1] & ~tick_sync_ff[2];

   // ****************************************************************
   // standby sequencer
   // ****************************************************************
   // stop is refused unless the cpu runs on the main clock
   assign stop_accept = (state_ff == ST_RUN) & stop_instr & cpu_on_main_clk; // R8
   assign at_limit    = (count_ff >= limit);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_RUN: begin
            if (stop_accept) begin
               nxt_state = ST_STOP; // R3
            end else if (halt_instr) begin
               nxt_state = ST_HALT; // R1
            end
         end
         ST_HALT: begin
            // oscillators never stopped, so no wait on the way out
            if (irq_pending) begin
               nxt_state = ST_RUN; // R2
            end
         end
         ST_STOP: begin
            if (irq_pending) begin // R4
               nxt_state = cpu_on_crystal ? ST_SETTLE : ST_RUN; // R5
            end
         end
         ST_SETTLE: begin
            if (at_limit) begin
               nxt_state = ST_RUN; // R17
            end
         end
         default: begin
            nxt_state = ST_RUN;
         end
      endcase
   end

   // clock and hold controls; subclock is outside this block and never gated
   assign nxt_ctl.cpu_clk_run     = (nxt_state == ST_RUN); // R1
   assign nxt_ctl.int_hs_osc_run  = (nxt_state != ST_STOP); // R3
   assign nxt_ctl.crystal_osc_run = (nxt_state != ST_STOP) & ~main_osc_halt_bit; // R3
   // hold freezes cpu-side registers, memory and port latches
   assign nxt_ctl.state_hold      = (nxt_state != ST_RUN); // R6 R7

   // async reset drops any standby mode straight back to run
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_RUN; // R18
         ctl_ff   <= CTL_RESET;
      end else begin
         state_ff <= nxt_state;
         ctl_ff   <= nxt_ctl;
      end
   end

   assign clk_ctl = ctl_ff;

   // ****************************************************************
   // settling counter
   // ****************************************************************
   // the select register should stay put while settling; a change
   // mid-count just moves the stopping point
   assign limit          = LIMIT_BY_CODE[sel_ff] >> SETTLE_SHIFT; // R14
   assign osc_ok         = ctl_ff.crystal_osc_run & alive_sync_ff[1]; // R15
   assign clear_progress = stop_accept | main_osc_halt_bit; // R12

   always_comb begin
      nxt_count = count_ff;
      if (clear_progress) begin
         nxt_count = CNT_ZERO; // R12
      end else if (osc_ok & tick_rise & ~at_limit) begin
         nxt_count = count_ff + CNT_ONE; // R14
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_ff <= CNT_ZERO;
      end else begin
         count_ff <= nxt_count;
      end
   end

   // ****************************************************************
   // progress flags
   // ****************************************************************
   // thermometer flags; clear wins because the count restarts with it
   for (genvar i = 0; i < FLAG_NUM; i++) begin : g_flag
      assign nxt_flags[i] = clear_progress ? 1'b0 :
         (flags_ff[i] | (count_ff >= (FLAG_THR[i] >> SETTLE_SHIFT))); // R13
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags_ff <= PROGRESS_RESET; // R12
      end else begin
         flags_ff <= nxt_flags; // R11
      end
   end

   // ****************************************************************
   // registers at their memory addresses
   // ****************************************************************
   assign sel_wr = reg_wr & (reg_addr == ADDR_SELECT);

   // prohibited codes are stored as written and settle at the longest time
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sel_ff <= SELECT_RESET; // R16
      end else if (sel_wr) begin
         sel_ff <= reg_wdata[SEL_W-1:0]; // R16
      end
   end

   // read data registered one cycle after the strobe; the progress
   // register is read-only and ignores writes
   always_comb begin
      nxt_rdata = rdata_ff;
      if (reg_rd) begin
         if (reg_addr == ADDR_PROGRESS) begin
            nxt_rdata = {3'h0, flags_ff}; // R11
         end else if (reg_addr == ADDR_SELECT) begin
            nxt_rdata = {5'h0_0, sel_ff};
         end else begin
            nxt_rdata = READ_ZERO;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_ff <= READ_ZERO;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

endmodule
`default_nettype wire

// ===== standby_osc_settle_control_checker.sv
`timescale 1ns/1ns
`default_nettype none
module settle_checker
   import standby_pkg::*;
#(
   parameter int unsigned SETTLE_SHIFT = 0
) (
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic              halt_instr,
   input wire logic              stop_instr,
   input wire logic              irq_pending,
   input wire logic              cpu_on_main_clk,
   input wire logic              cpu_on_crystal,
   input wire logic              main_osc_halt_bit,
   input wire logic [15:0]       reg_addr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire clk_ctl_t          clk_ctl
);
   // ****************************************
   // port relations, one domain
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // read decode; reads are never issued back to back, so ##2 sees the answer
   wire logic rd_prog = reg_rd && reg_addr == ADDR_PROGRESS;
   wire logic rd_sel  = reg_rd && reg_addr == ADDR_SELECT;

   a_halt_gates_cpu: assert property (
      clk_ctl.cpu_clk_run && halt_instr && !stop_instr |=>
      (clk_ctl.state_hold && clk_ctl.int_hs_osc_run && !clk_ctl.cpu_clk_run))
      else $error("halt did not gate cpu clock");
   a_stop_halts_osc: assert property (
      clk_ctl.cpu_clk_run && stop_instr && cpu_on_main_clk |=> clk_ctl == 4'b0001)
      else $error("stop did not halt oscillators");
   a_stop_main_only: assert property (
      clk_ctl.cpu_clk_run && stop_instr && !cpu_on_main_clk && !halt_instr
      |=> ##1 clk_ctl.cpu_clk_run) else $error("stop taken off main clock");
   a_stop_stays: assert property (
      (clk_ctl == 4'b0001 && !irq_pending)[*3] |=> clk_ctl == 4'b0001)
      else $error("stop left without request");
   a_wake_to_settle: assert property (
      clk_ctl == 4'b0001 && irq_pending && cpu_on_crystal && !main_osc_halt_bit
      |-> ##[1:2] clk_ctl == 4'b0111) else $error("no settle wait after stop");
   a_wake_to_run: assert property (
      clk_ctl == 4'b0001 && irq_pending && !cpu_on_crystal |-> ##[1:2] clk_ctl.cpu_clk_run)
      else $error("stop not released");
   a_hold_tracks: assert property (
      clk_ctl.state_hold != clk_ctl.cpu_clk_run) else $error("hold flag wrong");
   a_rdata_holds: assert property (
      !reg_rd && !$past(reg_rd) |=> $stable(reg_rdata)) else $error("read data moved");
   a_stop_clears: assert property (
      clk_ctl == 4'b0001 && rd_prog |-> ##2 reg_rdata == READ_ZERO)
      else $error("progress not clear in stop");
   a_halt_bit_osc: assert property (
      main_osc_halt_bit && $past(main_osc_halt_bit) |=> !clk_ctl.crystal_osc_run)
      else $error("crystal runs with halt bit");
   a_read_fields: assert property (
      rd_sel |-> ##2 reg_rdata[7:3] == 5'h00) else $error("select upper bits set");
endmodule
bind standby_osc_settle_control settle_checker #(.SETTLE_SHIFT(SETTLE_SHIFT)) chk_i (
   .clk, .rstn, .halt_instr, .stop_instr, .irq_pending, .cpu_on_main_clk, .cpu_on_crystal,
   .main_osc_halt_bit, .reg_addr, .reg_rd, .reg_rdata, .clk_ctl);
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import standby_pkg::*;
   // ****************************************
   // bench for the standby controller
   // ****************************************
   localparam int SH = 6; // shortens 2^11 to 32 ticks
   logic        clk, rstn, halt_instr, stop_instr, irq_pending, on_main, on_xtal;
   logic        osc_halt, tick, alive, rd, wr;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata;
   clk_ctl_t    ctl;
   logic [31:0] seed;
   int          fails, n_compared, lim, n;

   standby_osc_settle_control #(.SETTLE_SHIFT(SH)) dut (
      .clk(clk), .rstn(rstn), .halt_instr(halt_instr), .stop_instr(stop_instr),
      .irq_pending(irq_pending), .cpu_on_main_clk(on_main), .cpu_on_crystal(on_xtal),
      .main_osc_halt_bit(osc_halt), .main_crystal_osc_tick(tick),
      .main_crystal_osc_alive(alive), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
      .reg_wdata(wdata), .reg_rdata(rdata), .clk_ctl(ctl));

   // free running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // all helpers start and end at a falling edge
   task automatic cyc(input int c);
      repeat (c) @(negedge clk);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] e);
      n_compared++;
      if (got !== e) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, e);
      end
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      addr = a;
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
      cyc(2);
      chk(rdata, e);
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
   endtask
   // pulse halt, stop, irq; then look at the clock controls
   task automatic go(input logic [2:0] hsq, input logic [3:0] e);
      {halt_instr, stop_instr, irq_pending} = hsq;
      cyc(1);
      {halt_instr, stop_instr, irq_pending} = 3'b000;
      cyc(2);
      chk({4'h0, ctl}, {4'h0, e});
   endtask
   // crystal periods at a quarter of clk, the fastest allowed
   task automatic ticks(input int t);
      repeat (t) begin
         tick = 1'b1;
         cyc(2);
         tick = 1'b0;
         cyc(2);
      end
      cyc(10);
   endtask
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // thermometer flags after t periods, clipped at the selected limit
   function automatic logic [7:0] exp_prog(input int t, input logic [2:0] s);
      logic [7:0] f;
      f = 8'h00;
      if (t > int'(LIMIT_BY_CODE[s] >> SH)) t = int'(LIMIT_BY_CODE[s] >> SH);
      for (int i = 0; i < FLAG_NUM; i++) f[i] = (t >= int'(FLAG_THR[i] >> SH));
      return f;
   endfunction
   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // watchdog, well above the roughly 23k cycles of the run
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      $display("mismatch at %0t: run hung", $time);
      end_sim();
   end

   // main sequence
   initial begin
      {halt_instr, stop_instr, irq_pending, osc_halt, tick, rd, wr} = '0;
      {on_main, on_xtal, alive} = 3'b111;
      addr = 16'h0000;
      wdata = 8'h00;
      seed = 32'h0000_0056;
      fails = 0;
      n_compared = 0;
      rstn = 1'b0;
      cyc(16);
      rstn = 1'b1;
      cyc(2);
      rd_chk(ADDR_PROGRESS, READ_ZERO);
      rd_chk(ADDR_SELECT, 8'h05);
      rd_chk(16'hffa5, READ_ZERO);
      wr_reg(ADDR_PROGRESS, 8'hff);
      rd_chk(ADDR_PROGRESS, READ_ZERO);
      $display("registers done");
      ticks(31);
      rd_chk(ADDR_PROGRESS, READ_ZERO);
      ticks(1);
      rd_chk(ADDR_PROGRESS, exp_prog(32, SEL_2E16));
      alive = 1'b0;
      ticks(200);
      rd_chk(ADDR_PROGRESS, exp_prog(32, SEL_2E16));
      alive = 1'b1;
      osc_halt = 1'b1;
      ticks(100);
      go(3'b000, 4'b1010);
      rd_chk(ADDR_PROGRESS, READ_ZERO);
      osc_halt = 1'b0;
      $display("counter done");
      go(3'b100, 4'b0111);
      cyc(20);
      go(3'b000, 4'b0111);
      go(3'b010, 4'b0111);
      go(3'b001, 4'b1110);
      on_main = 1'b0;
      go(3'b010, 4'b1110);
      go(3'b100, 4'b0111);
      go(3'b001, 4'b1110);
      on_main = 1'b1;
      // no main-clock peripheral or converter exists here, so stop is legal whenever the cpu runs on the main clock
      go(3'b110, 4'b0001);
      ticks(50);
      rd_chk(ADDR_PROGRESS, READ_ZERO);
      on_xtal = 1'b0;
      go(3'b001, 4'b1110);
      on_xtal = 1'b1;
      $display("standby modes done");
      // every select code, including prohibited ones, at a random stop point
      for (int k = 0; k < 8; k++) begin
         lim = int'(LIMIT_BY_CODE[k] >> SH);
         n = int'(xs() % lim);
         wr_reg(ADDR_SELECT, 8'(k));
         rd_chk(ADDR_SELECT, 8'(k));
         go(3'b010, 4'b0001);
         rd_chk(ADDR_PROGRESS, READ_ZERO);
         go(3'b001, 4'b0111);
         ticks(n);
         chk({4'h0, ctl}, 8'h07);
         rd_chk(ADDR_PROGRESS, exp_prog(n, k[2:0]));
         ticks(lim - n + 40);
         chk({4'h0, ctl}, 8'h0e);
         rd_chk(ADDR_PROGRESS, exp_prog(lim, k[2:0]));
      end
      $display("settling done");
      go(3'b100, 4'b0111);
      rstn = 1'b0;
      cyc(2);
      chk({4'h0, ctl}, 8'h0e);
      rstn = 1'b1;
      cyc(2);
      rd_chk(ADDR_SELECT, 8'h05);
      rd_chk(ADDR_PROGRESS, READ_ZERO);
      $display("reset in standby done");
      end_sim();
   end
endmodule
`default_nettype wire
